// ==== psp_pkg.sv ====
// shared constants for the pixel stream port control block
package psp_pkg;

  // ----------------------------------------------------------------
  // frame geometry and sample width defaults
  // ----------------------------------------------------------------
  localparam int PSP_COLS     = 1920;       // active pixels per scan line
  localparam int PSP_ROWS     = 1080;       // active scan lines per frame
  localparam int PSP_PIX_BITS = 8;          // sensor sample width: 8, 10 or 12
  localparam int PSP_IN_NARROW = 8;         // input bus for 8 bit samples
  localparam int PSP_IN_WIDE   = 16;        // input bus for 10 and 12 bit samples
  localparam int PSP_BYTE      = 8;         // output bus grows in whole bytes
  localparam int PSP_COMPS     = 3;         // red, green, blue

  // ----------------------------------------------------------------
  // timing counts, buffer depth and widths
  // ----------------------------------------------------------------
  localparam int PSP_DELAY_LINES = 2;       // processing delay, whole lines
  localparam int PSP_DELAY_EXTRA = 18;      // processing delay, extra pixels
  localparam int PSP_LEND_GAP    = 2;       // ready low cycles after a line
  localparam int PSP_RST_HOLD    = 32;      // least core reset low time, cycles
  localparam int PSP_FIFO_DEPTH  = 8;       // output fifo words
  localparam int PSP_INTC_W      = 6;       // interrupt vector width
  localparam int PSP_CNT_W       = 16;      // row and column counter width

  // ----------------------------------------------------------------
  // interrupt vector bit positions
  // ----------------------------------------------------------------
  localparam int PSP_INTC_FRAME_START = 0;  // first pixel of a frame taken
  localparam int PSP_INTC_FLUSH_DONE  = 1;  // frame drained from the pipeline

  // input bus width for a sample width
  function automatic int psp_in_w(input int pix_bits);
    return (pix_bits > PSP_IN_NARROW) ? PSP_IN_WIDE : PSP_IN_NARROW;
  endfunction

  // output bus width: three components rounded up to whole bytes
  function automatic int psp_out_w(input int pix_bits);
    return ((PSP_COMPS * pix_bits + PSP_BYTE - 1) / PSP_BYTE) * PSP_BYTE;
  endfunction

endpackage

// ==== psp_stream_if.sv ====
// stream link between the video source and sink and the correction core
`timescale 1ns/100ps
`default_nettype none
interface psp_stream_if #(
  parameter int IN_W  = 8,
  parameter int OUT_W = 24
);
  // core clock enable and synchronous core reset, driven by the host
  logic             core_en;
  logic             core_rst_n;
  // raw pixel stream into the core
  logic [IN_W-1:0]  s_data;
  logic             s_valid;
  logic             s_ready;
  logic             s_frame_start;
  logic             s_line_end_marker;
  // corrected rgb stream out of the core
  logic [OUT_W-1:0] m_data;
  logic             m_valid;
  logic             m_ready;
  logic             m_frame_start;
  logic             m_line_end_marker;

  modport dev (
    input  core_en, core_rst_n,
    input  s_data, s_valid, s_frame_start, s_line_end_marker,
    output s_ready,
    output m_data, m_valid, m_frame_start, m_line_end_marker,
    input  m_ready
  );

  modport host (
    output core_en, core_rst_n,
    output s_data, s_valid, s_frame_start, s_line_end_marker,
    input  s_ready,
    input  m_data, m_valid, m_frame_start, m_line_end_marker,
    output m_ready
  );
endinterface
`default_nettype wire

// ==== psp_device.sv ====
// correction core stream end: output fifo and the stream port controller
//
// Overview of operation
// (R1) sample inputs, change outputs on rising clock
// (R2) enable low freezes state and outputs
// (R3) enable low ignores inputs except core reset
// (R4) active low synchronous reset beats enable
// (R5) reset driver holds low 32 cycles
// (R6) these controls touch only the stream side
// (R7) source sends 8/16 bit data, zero padded
// (R8) rgb out on 24/32/40 bits, zero padded
// (R9) transfer needs ready, valid, enable, reset high
// (R10) only active pixels cross the stream
// (R11) source holds signals until transfer completes
// (R12) source never withdraws valid before transfer
// (R13) source drives frame start and line end
// (R14) core drives frame start and line end
// (R15) optional six bit interrupt vector output
// (R16) irq only with control bus option
// (R17) frame start on first pixel only
// (R18) line end on last pixel only
// (R19) ready low two cycles after each line
// (R20) output delayed two lines plus 18 pixels
// (R21) output held stable until sink accepts
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// output fifo
// ------------------------------------------------------------------
module psp_fifo
  import psp_pkg::*;
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = PSP_FIFO_DEPTH       // power of two
) (
  // clock and resets
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             en,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the count
  assign in_ready  = (count_reg != FULL);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = en && in_valid && in_ready;
  assign pop       = en && out_valid && out_ready;

  // storage has no reset, the count says what is live
  always_ff @(posedge clk_sys) begin
    if (push && !clear) begin
      mem[wr_reg] <= in_data;
    end
  end

  // pointers and count freeze while the enable is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else if (clear) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;                  // head moves only on accept [R21]
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // psp_fifo

// ------------------------------------------------------------------
// stream port controller
// ------------------------------------------------------------------
module psp_device
  import psp_pkg::*;
#(
  parameter int COLS     = PSP_COLS,
  parameter int ROWS     = PSP_ROWS,
  parameter int PIX_BITS = PSP_PIX_BITS,
  parameter bit HAS_INTC = 1'b1
) (
  // system clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // link to source and sink
  psp_stream_if.dev                  link,
  // user side status
  output logic [PSP_INTC_W-1:0]      irq_vector_out,
  output logic                       flushing
);
  localparam int OUT_W = psp_out_w(PIX_BITS);
  localparam int DELAY = PSP_DELAY_LINES * COLS + PSP_DELAY_EXTRA;
  localparam int DW    = $clog2(DELAY);
  localparam int FW    = $clog2(DELAY + 1);
  localparam int EW    = PIX_BITS + 2;
  localparam logic [FW-1:0]        DELAY_V = FW'(DELAY);
  localparam logic [DW-1:0]        LAST_WP = DW'(DELAY - 1);
  localparam logic [PSP_CNT_W-1:0] LAST_ROW = PSP_CNT_W'(ROWS - 1);
  localparam logic [1:0]           GAP_V = 2'(PSP_LEND_GAP);

  typedef enum logic [0:0] {
    PSP_RUN,
    PSP_FLUSH
  } psp_state_type;

  psp_state_type       state_reg;
  logic [1:0]          gap_reg;
  logic [PSP_CNT_W-1:0] row_reg;
  logic [DW-1:0]       wp_reg;
  logic [FW-1:0]       fill_reg;
  logic [FW-1:0]       flush_reg;
  logic [EW-1:0]       dly_mem [DELAY];
  logic [EW-1:0]       new_entry;
  logic [EW-1:0]       old_entry;
  logic                live;
  logic                in_ready;
  logic                accept;
  logic                step;
  logic                emit;
  logic                flush_done;
  logic                fifo_in_ready;
  logic [OUT_W+1:0]    fifo_in;
  logic [OUT_W+1:0]    fifo_out;
  logic [PIX_BITS-1:0] pix;

  // core reset beats the enable; enable low freezes everything [R4] [R3]
  // only the stream side sees these controls; there is no control bus here
  assign live = link.core_rst_n && link.core_en;                    // [R2] [R6]

  // ready drops during the line gap, the flush and when the fifo is full
  assign in_ready    = (state_reg == PSP_RUN) && (gap_reg == '0) && fifo_in_ready;
  assign link.s_ready = in_ready;
  // a transfer counts only with ready, valid, enable and reset high
  assign accept = live && link.s_valid && in_ready;                 // [R9] [R1]
  // the delay line moves one slot per taken pixel or per flush slot
  assign step   = live && fifo_in_ready && (accept || state_reg == PSP_FLUSH);
  // flush slots carry nothing; only real pixels ever leave [R10]
  assign new_entry = (state_reg == PSP_FLUSH) ? '0 :
                     {link.s_frame_start, link.s_line_end_marker,
                      link.s_data[PIX_BITS-1:0]};
  assign old_entry = dly_mem[wp_reg];
  // oldest entry leaves once the line holds two lines plus 18 pixels
  assign emit       = step && (fill_reg == DELAY_V);                // [R20]
  assign flush_done = step && (state_reg == PSP_FLUSH) && (flush_reg == DELAY_V - 1'b1);
  assign flushing   = (state_reg == PSP_FLUSH);

  // ----------------------------------------------------------------
  // rgb packing
  // ----------------------------------------------------------------
  // all three components come from the stored sample; unused top bits are zero
  assign pix     = old_entry[PIX_BITS-1:0];
  assign fifo_in = {old_entry[EW-1], old_entry[EW-2],
                    OUT_W'({pix, pix, pix})};                       // [R8]

  // delay line storage, no reset needed since fill gates the output
  always_ff @(posedge clk_sys) begin
    if (step) begin
      dly_mem[wp_reg] <= new_entry;
    end
  end

  // write pointer wraps at the delay length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
    end else if (!link.core_rst_n) begin
      wp_reg <= '0;                                                 // [R4]
    end else if (step) begin
      wp_reg <= (wp_reg == LAST_WP) ? '0 : wp_reg + 1'b1;
    end
  end

  // fill level saturates at the delay; cleared after a frame drains
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fill_reg <= '0;
    end else if (!link.core_rst_n) begin
      fill_reg <= '0;
    end else if (flush_done) begin
      fill_reg <= '0;
    end else if (step && fill_reg != DELAY_V) begin
      fill_reg <= fill_reg + 1'b1;
    end
  end

  // two cycle gap after each line so the pipelines can empty
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gap_reg <= '0;
    end else if (!link.core_rst_n) begin
      gap_reg <= '0;
    end else if (link.core_en) begin                                // [R2]
      if (accept && link.s_line_end_marker) begin
        gap_reg <= GAP_V;                                           // [R19]
      end else if (gap_reg != '0) begin
        gap_reg <= gap_reg - 1'b1;
      end
    end
  end

  // line count and frame end flush
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= PSP_RUN;
      row_reg   <= '0;
      flush_reg <= '0;
    end else if (!link.core_rst_n) begin
      state_reg <= PSP_RUN;
      row_reg   <= '0;
      flush_reg <= '0;
    end else if (link.core_en) begin
      case (state_reg)
        PSP_RUN: begin
          if (accept && link.s_line_end_marker) begin
            if (row_reg == LAST_ROW) begin
              row_reg   <= '0;
              state_reg <= PSP_FLUSH;
            end else begin
              row_reg <= row_reg + 1'b1;
            end
          end
        end
        PSP_FLUSH: begin
          if (flush_done) begin
            flush_reg <= '0;
            state_reg <= PSP_RUN;
          end else if (step) begin
            flush_reg <= flush_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= PSP_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output fifo: sink back-pressure stalls the delay line through ready
  // ----------------------------------------------------------------
  psp_fifo #(
    .WIDTH (OUT_W + 2),
    .DEPTH (PSP_FIFO_DEPTH)
  ) u_out_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clear     (!link.core_rst_n),
    .en        (link.core_en),                                      // [R2]
    .in_data   (fifo_in),
    .in_valid  (emit),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (link.m_valid),
    .out_ready (link.m_ready)
  );

  // markers travel with their pixel, so each lands on one transfer
  assign link.m_frame_start     = fifo_out[OUT_W+1];                // [R14] [R17]
  assign link.m_line_end_marker = fifo_out[OUT_W];                  // [R18]
  assign link.m_data            = fifo_out[OUT_W-1:0];              // [R21]

  // ----------------------------------------------------------------
  // interrupt vector; no control bus in this build, so no irq pin [R16]
  // ----------------------------------------------------------------
  generate
    if (HAS_INTC) begin : g_intc
      logic [PSP_INTC_W-1:0] intc_reg;
      // one enabled cycle pulses on frame start and on frame drained [R15]
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          intc_reg <= '0;
        end else if (!link.core_rst_n) begin
          intc_reg <= '0;
        end else if (link.core_en) begin
          intc_reg <= '0;
          intc_reg[PSP_INTC_FRAME_START] <= accept && link.s_frame_start;
          intc_reg[PSP_INTC_FLUSH_DONE]  <= flush_done;
        end
      end
      assign irq_vector_out = intc_reg;
    end else begin : g_no_intc
      assign irq_vector_out = '0;                                   // option absent [R15]
    end
  endgenerate
endmodule // psp_device
`default_nettype wire

// ==== psp_host.sv ====
// source and sink end: reset and enable driver, frame generator, pixel catcher
`timescale 1ns/100ps
`default_nettype none
module psp_host
  import psp_pkg::*;
#(
  parameter int COLS     = PSP_COLS,
  parameter int ROWS     = PSP_ROWS,
  parameter int PIX_BITS = PSP_PIX_BITS
) (
  // system clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // link to the core
  psp_stream_if.host                         link,
  // user control
  input  wire logic                          run_en,
  input  wire logic                          frame_go,
  input  wire logic                          sink_hold,
  // user status
  output logic                               core_in_reset,
  output logic                               frame_sent,
  // captured output pixels
  output logic [psp_out_w(PIX_BITS)-1:0]     cap_data,
  output logic                               cap_frame_start,
  output logic                               cap_line_end,
  output logic                               cap_strobe
);
  localparam int IN_W = psp_in_w(PIX_BITS);
  localparam logic [5:0]           HOLD_V   = 6'(PSP_RST_HOLD - 1);
  localparam logic [PSP_CNT_W-1:0] LAST_COL = PSP_CNT_W'(COLS - 1);
  localparam logic [PSP_CNT_W-1:0] LAST_ROW = PSP_CNT_W'(ROWS - 1);

  typedef enum logic [0:0] {
    PSP_IDLE,
    PSP_SEND
  } psp_src_type;

  psp_src_type          src_reg;
  logic [5:0]           hold_reg;
  logic                 rst_n_reg;
  logic                 en_reg;
  logic [PSP_CNT_W-1:0] col_reg;
  logic [PSP_CNT_W-1:0] row_reg;
  logic                 valid_reg;
  logic [IN_W-1:0]      data_reg;
  logic                 sof_reg;
  logic                 lend_reg;
  logic                 taken;
  logic                 caught;
  logic [PSP_CNT_W-1:0] pix_val;

  // core reset held low 32 cycles after system reset [R5]
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_reg  <= '0;
      rst_n_reg <= 1'b0;
    end else if (!rst_n_reg) begin
      hold_reg  <= hold_reg + 1'b1;
      rst_n_reg <= (hold_reg == HOLD_V);
    end
  end

  // enable is a registered copy of the user request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= run_en;
    end
  end

  assign link.core_rst_n = rst_n_reg;
  assign link.core_en    = en_reg;
  assign core_in_reset   = !rst_n_reg;

  // transfer counts only with ready, valid, enable and reset all high [R9]
  assign taken  = link.s_valid && link.s_ready && en_reg && rst_n_reg;
  assign caught = link.m_valid && link.m_ready && en_reg && rst_n_reg;
  // test pattern, zero padded above the sample width [R7]
  assign pix_val = col_reg + row_reg;

  // ----------------------------------------------------------------
  // source: one frame of active pixels per go request [R10]
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_reg    <= PSP_IDLE;
      col_reg    <= '0;
      row_reg    <= '0;
      valid_reg  <= 1'b0;
      data_reg   <= '0;
      sof_reg    <= 1'b0;
      lend_reg   <= 1'b0;
      frame_sent <= 1'b0;
    end else begin
      frame_sent <= 1'b0;
      case (src_reg)
        PSP_IDLE: begin
          if (frame_go && rst_n_reg) begin
            src_reg <= PSP_SEND;
            col_reg <= '0;
            row_reg <= '0;
          end
        end
        PSP_SEND: begin
          // signals stand until taken; valid never withdrawn [R11] [R12]
          if (!valid_reg || taken) begin
            if (valid_reg && lend_reg && row_reg == LAST_ROW) begin
              valid_reg  <= 1'b0;
              src_reg    <= PSP_IDLE;
              frame_sent <= 1'b1;
            end else begin
              valid_reg <= 1'b1;
              data_reg  <= IN_W'(pix_val[PIX_BITS-1:0]);
              // valid is low only before the first load of a frame, so the
              // marker cannot repeat on a later row's first pixel
              sof_reg   <= !valid_reg;                               // [R13] [R17]
              lend_reg  <= (col_reg == LAST_COL);                    // [R18]
              if (valid_reg && lend_reg) begin
                row_reg <= row_reg + 1'b1;
              end
              col_reg <= (col_reg == LAST_COL) ? '0 : col_reg + 1'b1;
            end
          end
        end
        default: begin
          src_reg <= PSP_IDLE;
        end
      endcase
    end
  end

  assign link.s_valid           = valid_reg;
  assign link.s_data            = data_reg;
  assign link.s_frame_start     = sof_reg;
  assign link.s_line_end_marker = lend_reg;

  // ----------------------------------------------------------------
  // sink: stalls on request so the core's fifo really fills
  // ----------------------------------------------------------------
  assign link.m_ready = rst_n_reg && !sink_hold;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_data        <= '0;
      cap_frame_start <= 1'b0;
      cap_line_end    <= 1'b0;
      cap_strobe      <= 1'b0;
    end else begin
      cap_strobe <= caught;
      if (caught) begin
        cap_data        <= link.m_data;
        cap_frame_start <= link.m_frame_start;
        cap_line_end    <= link.m_line_end_marker;
      end
    end
  end
endmodule // psp_host
`default_nettype wire

// ==== psp_stream_checker.sv ====
// assertions on the stream link between host end and core end
`timescale 1ns/100ps
`default_nettype none
module psp_stream_checker
  import psp_pkg::*;
#(
  parameter int COLS = 4,
  parameter int ROWS = 8,
  parameter int PIX_BITS = 10,
  parameter int IN_W = 16,
  parameter int OUT_W = 32
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic core_en,
  input wire logic core_rst_n,
  // input stream
  input wire logic [IN_W-1:0] s_data,
  input wire logic s_valid,
  input wire logic s_ready,
  input wire logic s_frame_start,
  input wire logic s_line_end_marker,
  // output stream
  input wire logic [OUT_W-1:0] m_data,
  input wire logic m_valid,
  input wire logic m_ready,
  input wire logic m_frame_start,
  input wire logic m_line_end_marker
);
  localparam int FRAME = COLS * ROWS;
  localparam int DELAY = PSP_DELAY_LINES * COLS + PSP_DELAY_EXTRA;
  logic s_xfer;
  logic m_xfer;
  int in_tot_reg;
  int out_tot_reg;
  int low_cnt_reg;
  // a transfer needs both handshake halves, the enable and no core reset
  assign s_xfer = s_valid && s_ready && core_en && core_rst_n;
  assign m_xfer = m_valid && m_ready && core_en && core_rst_n;
  // transfer totals since the last core reset; position in frame is total mod size
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !core_rst_n) begin
      in_tot_reg <= 0;
      out_tot_reg <= 0;
    end else begin
      in_tot_reg <= in_tot_reg + int'(s_xfer);
      out_tot_reg <= out_tot_reg + int'(m_xfer);
    end
  end
  // saturating count of core reset low cycles, enough to judge the hold time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || core_rst_n) low_cnt_reg <= 0;
    else if (low_cnt_reg < PSP_RST_HOLD) low_cnt_reg <= low_cnt_reg + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  a_line_gap: assert property (s_xfer && s_line_end_marker |=> !s_ready [*2])
    else $error("input ready not low after line end");
  a_en_freeze: assert property (!core_en && core_rst_n |=> $stable(m_valid) &&
    $stable(m_data) && $stable(s_ready)) else $error("outputs moved while disabled");
  a_out_hold: assert property (m_valid && !m_ready && core_rst_n |=> m_valid &&
    $stable(m_data) && $stable(m_frame_start) && $stable(m_line_end_marker))
    else $error("output changed before accept");
  a_src_hold: assert property (s_valid && !(s_ready && core_en) && core_rst_n |=>
    s_valid && $stable(s_data) && $stable(s_frame_start) && $stable(s_line_end_marker))
    else $error("source changed before accept");
  a_core_reset: assert property (!core_rst_n |=> !m_valid)
    else $error("output valid after core reset");
  a_rst_hold: assert property ($rose(core_rst_n) |-> low_cnt_reg >= PSP_RST_HOLD)
    else $error("core reset released too early");
  a_in_mark: assert property (s_xfer |-> s_frame_start == (in_tot_reg % FRAME == 0) &&
    s_line_end_marker == (in_tot_reg % COLS == COLS - 1)) else $error("input markers wrong");
  a_out_mark: assert property (m_xfer |-> m_frame_start == (out_tot_reg % FRAME == 0) &&
    m_line_end_marker == (out_tot_reg % COLS == COLS - 1)) else $error("output markers wrong");
  a_in_pad: assert property (s_valid |-> (s_data >> PIX_BITS) == 0)
    else $error("input padding not zero");
  a_out_pad: assert property (m_valid |-> (m_data >> (3 * PIX_BITS)) == 0)
    else $error("output padding not zero");
  a_out_latency: assert property (m_xfer |-> out_tot_reg + DELAY < in_tot_reg ||
    in_tot_reg >= FRAME * (out_tot_reg / FRAME + 1)) else $error("output pixel too early");
endmodule // psp_stream_checker
`default_nettype wire

// ==== pixel_stream_port_control_tb.sv ====
// bench: host end and core end joined by one stream link
`timescale 1ns/100ps
`default_nettype none
module pixel_stream_port_control_tb;
  import psp_pkg::*;
  localparam int COLS = 4;
  localparam int ROWS = 8; // frame must hold more pixels than the pipeline delay
  localparam int PIX = 10;
  localparam int IW = 16;
  localparam int OW = 32;
  localparam int FRAME = COLS * ROWS;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic frame_go = 1'b0;
  logic run_en = 1'b0;
  logic sink_hold = 1'b0;
  logic stall = 1'b0;
  logic pause = 1'b0;
  logic [PSP_INTC_W-1:0] irq_vector_out;
  logic flushing, core_in_reset, frame_sent, cap_frame_start, cap_line_end, cap_strobe;
  logic [OW-1:0] cap_data;
  logic [IW-1:0] sent_q[$];
  logic [IW-1:0] exp_pix;
  int errors = 0;
  int num_checks = 0;
  int n_cap, n_sof, n_end;
  int cyc = 0;
  psp_stream_if #(.IN_W(IW), .OUT_W(OW)) link ();
  psp_device #(.COLS(COLS), .ROWS(ROWS), .PIX_BITS(PIX), .HAS_INTC(1'b1)) u_psp_device (
    .clk_sys(clk_sys), .rst(rst), .link(link.dev), .irq_vector_out(irq_vector_out),
    .flushing(flushing));
  psp_host #(.COLS(COLS), .ROWS(ROWS), .PIX_BITS(PIX)) u_psp_host (
    .clk_sys(clk_sys), .rst(rst), .link(link.host), .run_en(run_en), .frame_go(frame_go),
    .sink_hold(sink_hold), .core_in_reset(core_in_reset), .frame_sent(frame_sent),
    .cap_data(cap_data), .cap_frame_start(cap_frame_start), .cap_line_end(cap_line_end),
    .cap_strobe(cap_strobe));
  psp_stream_checker #(.COLS(COLS), .ROWS(ROWS), .PIX_BITS(PIX), .IN_W(IW), .OUT_W(OW))
  u_psp_stream_checker (
    .clk_sys(clk_sys), .rst(rst), .core_en(link.core_en), .core_rst_n(link.core_rst_n),
    .s_data(link.s_data), .s_valid(link.s_valid), .s_ready(link.s_ready),
    .s_frame_start(link.s_frame_start), .s_line_end_marker(link.s_line_end_marker),
    .m_data(link.m_data), .m_valid(link.m_valid), .m_ready(link.m_ready),
    .m_frame_start(link.m_frame_start), .m_line_end_marker(link.m_line_end_marker));
  // 40 MHz core clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----
  // tasks
  // ----
  // one comparison, counted, reported at once on a miss
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // frame_go is held until the first pixel is offered, so the core reset hold cannot swallow it
  task automatic start_frame();
    int n;
    n = 0;
    frame_go = 1'b1;
    while (link.s_valid !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    frame_go = 1'b0;
    check(n < 200, "frame did not start");
    if (n >= 200) wrap_up();
  endtask
  task automatic wait_cap(input int target);
    int n;
    n = 0;
    while (n_cap < target && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check(n_cap == target, "output pixel count");
    if (n_cap < target) wrap_up();
  endtask
  // stall holds long enough to fill the fifo; pause drops the enable mid-line
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    sink_hold <= stall && (cyc % 16 < 12);
    run_en <= !(pause && cyc % 16 >= 10);
  end
  // record accepted input pixels, compare every captured output pixel
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sent_q.delete();
      n_cap <= 0;
      n_sof <= 0;
      n_end <= 0;
    end else begin
      if (link.s_valid && link.s_ready && link.core_en && link.core_rst_n)
        sent_q.push_back(link.s_data);
      // a pulse stands while the enable is low, so count it once, with enable high
      n_sof <= n_sof + int'(irq_vector_out[PSP_INTC_FRAME_START] === 1'b1 &&
                            link.core_en === 1'b1);
      n_end <= n_end + int'(frame_sent === 1'b1) +
               int'(irq_vector_out[PSP_INTC_FLUSH_DONE] === 1'b1 && link.core_en === 1'b1);
      if (cap_strobe === 1'b1) begin
        exp_pix = (sent_q.size() > 0) ? sent_q.pop_front() : '1;
        check(cap_data === {2'b00, {3{exp_pix[PIX-1:0]}}}, "pixel value");
        check(cap_frame_start === (n_cap % FRAME == 0), "frame start");
        check(cap_line_end === (n_cap % COLS == COLS - 1), "line end");
        n_cap <= n_cap + 1;
      end
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    start_frame();
    wait_cap(FRAME);
    stall = 1'b1;
    start_frame();
    wait_cap(2 * FRAME);
    stall = 1'b0;
    pause = 1'b1;
    start_frame();
    wait_cap(3 * FRAME);
    pause = 1'b0;
    check(n_sof === 3 && n_end === 6 && flushing === 1'b0, "frame event counts");
    start_frame();
    repeat (40) @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(link.core_rst_n === 1'b0 && link.m_valid === 1'b0 && core_in_reset === 1'b1,
          "core reset state");
    start_frame();
    wait_cap(FRAME);
    wrap_up();
  end
endmodule // pixel_stream_port_control_tb
`default_nettype wire
